// file: rtl/csw_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  chip select / wait controller.
  Assumes an 8-bit register port with byte offsets as listed here.
*/
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

// ==========================================================================
// Register offsets
`define CSW_OFS_AREA0_CTRL   8'hC0
`define CSW_OFS_AREA1_CTRL   8'hC1
`define CSW_OFS_AREA2_CTRL   8'hC2
`define CSW_OFS_AREA3_CTRL   8'hC3
`define CSW_OFS_DEFAULT_CTRL 8'hC7
`define CSW_OFS_AREA0_START  8'hC8
`define CSW_OFS_AREA0_MASK   8'hC9
`define CSW_OFS_AREA1_START  8'hCA
`define CSW_OFS_AREA1_MASK   8'hCB
`define CSW_OFS_AREA2_START  8'hCC
`define CSW_OFS_AREA2_MASK   8'hCD
`define CSW_OFS_AREA3_START  8'hCE
`define CSW_OFS_AREA3_MASK   8'hCF
`define CSW_OFS_STATUS       8'hD0

// ==========================================================================
// Control register fields
`define CSW_BIT_ENABLE       3'd7
`define CSW_BIT_MAP_SELECT   3'd6
`define CSW_BIT_TYPE_HI      3'd5
`define CSW_BIT_TYPE_LO      3'd4
`define CSW_BIT_BUS_WIDTH    3'd3
`define CSW_TYPE_ROM_SRAM    2'h0
`define CSW_TYPE_DRAM        2'h2

// ==========================================================================
// Reset values
`define CSW_RST_CTRL         8'h00
`define CSW_RST_START        8'hFF
`define CSW_RST_MASK         8'hFF

// ==========================================================================
// Wait codes and the number of wait cycles each inserts
`define CSW_WAIT_CODE_EXT    3'h2
`define CSW_WAITS_C0         4'h2
`define CSW_WAITS_C1         4'h1
`define CSW_WAITS_C2         4'h1
`define CSW_WAITS_C3         4'h0
`define CSW_WAITS_C4         4'h2
`define CSW_WAITS_C5         4'h3
`define CSW_WAITS_C6         4'h4
`define CSW_WAITS_C7         4'h8

`endif

// file: rtl/csw_pkg.sv
/*
  Types shared by the chip select / wait controller files.
  Assumes csw_regs.svh holds the numeric constants.
*/
package csw_pkg;

  // ========================================================================
  // Access sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_DONE   = 3'b100
  } access_state_e;

  // Area that won the decode
  typedef enum logic [2:0] {
    AREA_0       = 3'h0,
    AREA_1       = 3'h1,
    AREA_2       = 3'h2,
    AREA_3       = 3'h3,
    AREA_DEFAULT = 3'h4
  } area_e;

endpackage : csw_pkg

// file: rtl/area_match.sv
/*
  Address comparator of one chip select area.
  Assumes the caller has already widened the mask register to one mask bit
  per address bit A23..A8; start covers A23..A16, lower bits compare to 0.
*/
`timescale 1ns/1ns
module area_match (
  // Compare values
  input  wire logic [7:0]  start,
  input  wire logic [15:0] mask_wide,
  // Address under test, bits 23..8
  input  wire logic [15:0] addr_hi,
  // Result
  output logic             hit
);

  logic [15:0] want;  // Expected address bits

  // ========================================================================
  // Compare: a clear mask bit takes part, a set one is ignored
  always_comb begin
    want = {start, 8'h00};
    hit  = (((addr_hi ^ want) & ~mask_wide) == 16'h0000);
  end

endmodule : area_match

// file: rtl/chip_select_wait_controller.sv
/*
  Chip select and wait state controller for an external memory bus: four
  block areas decoded by start address and mask, each with enable, bus width
  and wait count (memory type on area 3 only), plus a default area with bus width and wait count.
  Assumes a same-clock access requester (start pulse plus 24-bit address)
  and an external wait pin that is asynchronous and active low.
*/
// Contract
// - Type 00 ROM/SRAM; block 3 10 DRAM
// - Bus width bit: 0 16-bit, 1 8-bit
// - Wait code sets inserted wait states
// - Start register compares A23..A16, resets ones
// - Mask bit 0 compares, 1 ignores
`timescale 1ns/1ns
`include "csw_regs.svh"
module chip_select_wait_controller
  import csw_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Access request from the bus unit
  input  wire logic        acc_start,
  input  wire logic [23:0] acc_addr,
  // External wait request pin
  input  wire logic        ext_wait_n,
  // Memory side results
  output logic [3:0]       area_select_n,
  output logic             dynamic_memory_controller,
  output logic             bus_8bit,
  output logic             acc_ready,
  output logic             acc_busy
);

  // ========================================================================
  // Functions

  // Wait states for a three-bit code
  function automatic logic [3:0] wait_count(input logic [2:0] code);
    logic [3:0] w;
    w = `CSW_WAITS_C0;
    unique case (code)
      3'h0: w = `CSW_WAITS_C0;
      3'h1: w = `CSW_WAITS_C1;
      3'h2: w = `CSW_WAITS_C2;
      3'h3: w = `CSW_WAITS_C3;
      3'h4: w = `CSW_WAITS_C4;
      3'h5: w = `CSW_WAITS_C5;
      3'h6: w = `CSW_WAITS_C6;
      3'h7: w = `CSW_WAITS_C7;
    endcase
    return w;
  endfunction : wait_count

  // Spread a mask register over A23..A8; areas 0 and 1 have their own layouts, areas 2 and 3 share one
  function automatic logic [15:0] widen_mask(input logic [1:0] idx,
                                             input logic [7:0] m);
    logic [15:0] r;
    r = 16'h0000;
    unique case (idx)
      2'd0:    r = {3'b000, m[7:2], {6{m[1]}}, m[0]};
      2'd1:    r = {2'b00, m[7:2], {7{m[1]}}, m[0]};
      default: r = {1'b0, m, 7'h00};
    endcase
    return r;
  endfunction : widen_mask

  // ========================================================================
  // Registers
  logic [7:0]    area_ctrl [4];   // Block area control, write only
  logic [7:0]    default_ctrl;    // Default area control, write only
  logic [7:0]    area_start [4];  // Start address A23..A16
  logic [7:0]    area_mask [4];   // Area size masks
  logic [3:0]    hit;             // Raw comparator hits
  logic          ext_wait_meta;   // Wait pin synchroniser, first stage
  logic          ext_wait_sync;   // Wait pin synchroniser, second stage
  access_state_e state;           // Access sequencer
  logic [3:0]    wait_left;       // Remaining fixed wait cycles
  logic          wait_ext;        // Current access honours the wait pin
  area_e         cur_area;        // Area of current or last access

  // Decode results
  area_e         next_area;
  logic [2:0]    next_code;
  logic          next_width;
  logic          next_dram;

  // ========================================================================
  // Register writes. Control registers have no read path, so partial
  // updates would lose bits; software writes them whole.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        area_ctrl[i]  <= `CSW_RST_CTRL;
        area_start[i] <= `CSW_RST_START;
        area_mask[i]  <= `CSW_RST_MASK;
      end
      default_ctrl <= `CSW_RST_CTRL;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        `CSW_OFS_AREA0_CTRL:   area_ctrl[0]  <= reg_wdata;
        `CSW_OFS_AREA1_CTRL:   area_ctrl[1]  <= reg_wdata;
        `CSW_OFS_AREA2_CTRL:   area_ctrl[2]  <= reg_wdata;
        `CSW_OFS_AREA3_CTRL:   area_ctrl[3]  <= reg_wdata;
        `CSW_OFS_DEFAULT_CTRL: default_ctrl  <= reg_wdata;
        `CSW_OFS_AREA0_START:  area_start[0] <= reg_wdata;
        `CSW_OFS_AREA0_MASK:   area_mask[0]  <= reg_wdata;
        `CSW_OFS_AREA1_START:  area_start[1] <= reg_wdata;
        `CSW_OFS_AREA1_MASK:   area_mask[1]  <= reg_wdata;
        `CSW_OFS_AREA2_START:  area_start[2] <= reg_wdata;
        `CSW_OFS_AREA2_MASK:   area_mask[2]  <= reg_wdata;
        `CSW_OFS_AREA3_START:  area_start[3] <= reg_wdata;
        `CSW_OFS_AREA3_MASK:   area_mask[3]  <= reg_wdata;
        // Unmapped and read-only offsets: write ignored
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Register reads, data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_rd) begin
        unique case (reg_addr)
          `CSW_OFS_AREA0_START: reg_rdata <= area_start[0];
          `CSW_OFS_AREA0_MASK:  reg_rdata <= area_mask[0];
          `CSW_OFS_AREA1_START: reg_rdata <= area_start[1];
          `CSW_OFS_AREA1_MASK:  reg_rdata <= area_mask[1];
          `CSW_OFS_AREA2_START: reg_rdata <= area_start[2];
          `CSW_OFS_AREA2_MASK:  reg_rdata <= area_mask[2];
          `CSW_OFS_AREA3_START: reg_rdata <= area_start[3];
          `CSW_OFS_AREA3_MASK:  reg_rdata <= area_mask[3];
          // Sequencer state for software diagnostics
          `CSW_OFS_STATUS:      reg_rdata <= {4'h0, acc_busy, cur_area};
          // Control registers and unmapped offsets read as zero
          default:              reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ========================================================================
  // Area comparators, one per block area
  for (genvar g = 0; g < 4; g++) begin : g_match
    area_match u_match (
      .start     (area_start[g]),
      .mask_wide (widen_mask(2'(g), area_mask[g])),
      .addr_hi   (acc_addr[23:8]),
      .hit       (hit[g])
    );
  end

  // ========================================================================
  // Area decode: block 0 has the highest priority, default area last
  always_comb begin
    next_area  = AREA_DEFAULT;
    next_code  = default_ctrl[2:0];
    next_width = default_ctrl[`CSW_BIT_BUS_WIDTH];
    next_dram  = 1'b0;
    if (area_ctrl[0][`CSW_BIT_ENABLE] && hit[0]) begin
      next_area = AREA_0;
    end else if (area_ctrl[1][`CSW_BIT_ENABLE] && hit[1]) begin
      next_area = AREA_1;
    end else if (area_ctrl[2][`CSW_BIT_ENABLE] &&
                 (hit[2] || !area_ctrl[2][`CSW_BIT_MAP_SELECT])) begin
      // Map select clear makes area 2 cover all 16 Mbytes
      next_area = AREA_2;
    end else if (area_ctrl[3][`CSW_BIT_ENABLE] && hit[3]) begin
      next_area = AREA_3;
    end
    if (next_area != AREA_DEFAULT) begin
      next_code  = area_ctrl[next_area[1:0]][2:0];
      next_width = area_ctrl[next_area[1:0]][`CSW_BIT_BUS_WIDTH];
    end
    if (next_area == AREA_3 &&
        area_ctrl[3][`CSW_BIT_TYPE_HI:`CSW_BIT_TYPE_LO] == `CSW_TYPE_DRAM) begin
      next_dram = 1'b1;
    end
  end

  // ========================================================================
  // Wait pin synchroniser; only the second stage is read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_wait_meta <= 1'b0;
      ext_wait_sync <= 1'b0;
    end else if (ce) begin
      ext_wait_meta <= ~ext_wait_n;
      ext_wait_sync <= ext_wait_meta;
    end
  end

  // ========================================================================
  // Access sequencer. Starts outside idle are ignored; the requester
  // watches acc_busy. Waits count whole clk_sys cycles.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state                     <= ST_IDLE;
      wait_left                 <= 4'h0;
      wait_ext                  <= 1'b0;
      cur_area                  <= AREA_DEFAULT;
      area_select_n             <= 4'hF;
      dynamic_memory_controller <= 1'b0;
      bus_8bit                  <= 1'b0;
      acc_ready                 <= 1'b0;
      acc_busy                  <= 1'b0;
    end else if (ce) begin
      unique case (state)
        ST_IDLE: begin
          if (acc_start) begin
            state     <= ST_ACTIVE;
            acc_busy  <= 1'b1;
            cur_area  <= next_area;
            wait_left <= wait_count(next_code);
            wait_ext  <= (next_code == `CSW_WAIT_CODE_EXT);
            bus_8bit  <= next_width;
            dynamic_memory_controller <= next_dram;
            if (next_area != AREA_DEFAULT && !next_dram) begin
              area_select_n <= ~(4'h1 << next_area[1:0]);
            end
          end
        end
        ST_ACTIVE: begin
          if (wait_left != 4'h0) begin
            wait_left <= wait_left - 4'h1;
          end else if (!(wait_ext && ext_wait_sync)) begin
            acc_ready <= 1'b1;
            state     <= ST_DONE;
          end
        end
        ST_DONE: begin
          acc_ready                 <= 1'b0;
          acc_busy                  <= 1'b0;
          area_select_n             <= 4'hF;
          dynamic_memory_controller <= 1'b0;
          state                     <= ST_IDLE;
        end
        default: begin
          // Illegal one-hot code: recover to idle
          state         <= ST_IDLE;
          acc_busy      <= 1'b0;
          acc_ready     <= 1'b0;
          area_select_n <= 4'hF;
        end
      endcase
    end
  end

endmodule : chip_select_wait_controller

// file: testbench/csw_checker_assertions.sv
/*
  Port checker of the chip select / wait controller.
  Assumes it is bound to the top module and sees one clock domain.
*/
`timescale 1ns/1ns
module csw_checker (
  // Clock, reset, enable
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ce,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Access side
  input wire logic        acc_start,
  input wire logic [23:0] acc_addr,
  input wire logic        ext_wait_n,
  input wire logic [3:0]  area_select_n,
  input wire logic        dynamic_memory_controller,
  input wire logic        bus_8bit,
  input wire logic        acc_ready,
  input wire logic        acc_busy
);
  // ==================================================================
  // Shadow of what software wrote
  logic [3:0] en_seen;    // Area enables
  logic [1:0] type3;      // Area 3 memory type
  logic [7:0] shadow [8]; // Start and mask registers
  logic [7:0] rd_exp;     // Read data due next cycle

  // Writes are whole bytes, so no merging is needed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_seen <= 4'h0;
      type3 <= 2'h0;
      rd_exp <= 8'h00;
      for (int i = 0; i < 8; i++) shadow[i] <= 8'hFF;
    end else if (ce) begin
      if (reg_wr && reg_addr[7:2] == 6'h30)
        en_seen[reg_addr[1:0]] <= reg_wdata[7];
      if (reg_wr && reg_addr == 8'hC3) type3 <= reg_wdata[5:4];
      if (reg_wr && reg_addr[7:3] == 5'h19)
        shadow[reg_addr[2:0]] <= reg_wdata;
      if (reg_rd) rd_exp <= shadow[reg_addr[2:0]];
    end
  end

  // ==================================================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_take;
    acc_start && !acc_busy && ce;
  endsequence
  sequence s_done;
    acc_ready ##1 (!acc_ready && !acc_busy && area_select_n == 4'hF);
  endsequence

  a_select_needs_en: assert property (
    (~area_select_n & ~en_seen) == 4'h0) else $error("select while off");
  a_select_onehot: assert property (
    $onehot0(~area_select_n)) else $error("two selects at once");
  a_select_in_busy: assert property (
    area_select_n != 4'hF |-> acc_busy) else $error("select when idle");
  a_dram_route: assert property (
    dynamic_memory_controller |-> type3 == 2'h2 && en_seen[3]
    && area_select_n[3]) else $error("dram route wrong");
  a_start_busy: assert property (
    s_take |=> acc_busy && !acc_ready) else $error("start not taken");
  a_ready_bound: assert property (
    s_take |-> ##[2:16] acc_ready) else $error("ready late");
  a_ready_release: assert property (
    acc_ready |-> s_done) else $error("release wrong");
  a_addr_readback: assert property (
    reg_rd && ce && reg_addr[7:3] == 5'h19 |=> reg_rdata == rd_exp)
    else $error("address register readback wrong");
endmodule : csw_checker

bind chip_select_wait_controller csw_checker i_chk (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .acc_start(acc_start), .acc_addr(acc_addr),
  .ext_wait_n(ext_wait_n), .area_select_n(area_select_n),
  .dynamic_memory_controller(dynamic_memory_controller),
  .bus_8bit(bus_8bit), .acc_ready(acc_ready), .acc_busy(acc_busy));

// file: testbench/mem_wait_model.sv
/*
  Slow external memory: while a hold count is set it keeps the wait pin
  low until it has been selected for that many cycles. It drives the
  pin high itself when the hold count is zero.
*/
`timescale 1ns/1ns
module mem_wait_model (
  // Clock
  input wire logic       clk_sys,
  // Memory side
  input wire logic [3:0] area_select_n,
  input wire logic [3:0] hold_cycles,
  output logic           ext_wait_n
);
  logic [3:0] cnt = 4'h0; // Cycles spent selected

  // Count while selected, restart when released
  always_ff @(posedge clk_sys) begin
    cnt <= (&area_select_n) ? 4'h0 : cnt + ((cnt != 4'hF) ? 4'h1 : 4'h0);
  end

  // external wait request. A busy device already holds the pin
  // low before its select falls, so the controller's two-stage
  // synchroniser sees the request before the one fixed wait runs out.
  assign ext_wait_n = (cnt >= hold_cycles);
endmodule : mem_wait_model

// file: testbench/test_chip_select_wait_controller.sv
/*
  Self-checking bench of the chip select / wait controller.
  Assumes the slow memory model on the wait pin.
*/
`timescale 1ns/1ns
module test_chip_select_wait_controller;
  // ==================================================================
  // Signals
  logic clk_sys, rst, ce, reg_wr, reg_rd, acc_start, ext_wait_n;
  logic dmc, bus_8bit, acc_ready, acc_busy;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [23:0] acc_addr;
  logic [3:0]  area_select_n, hold;
  int          mismatches = 0, comparisons = 0;
  int          w [8] = '{2, 1, 1, 0, 2, 3, 4, 8}; // Waits per code

  chip_select_wait_controller i_dut (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_start(acc_start), .acc_addr(acc_addr), .ext_wait_n(ext_wait_n),
    .area_select_n(area_select_n), .dynamic_memory_controller(dmc),
    .bus_8bit(bus_8bit), .acc_ready(acc_ready), .acc_busy(acc_busy));
  mem_wait_model i_mem (.clk_sys(clk_sys), .area_select_n(area_select_n),
    .hold_cycles(hold), .ext_wait_n(ext_wait_n));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==================================================================
  // Tasks
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask : rd
  // Latency 0 means only a stretch beyond three cycles is expected
  task acc(input logic [23:0] a, input logic [3:0] es, input logic ed,
           input logic eb, input int el);
    int lat;
    @(posedge clk_sys);
    acc_start <= 1'b1;
    acc_addr <= a;
    @(posedge clk_sys);
    acc_start <= 1'b0;
    #1 chk("select", {4'h0, es}, {4'h0, area_select_n});
    chk("dram", {7'h0, ed}, {7'h0, dmc});
    chk("width", {7'h0, eb}, {7'h0, bus_8bit});
    chk("busy", 8'h01, {7'h0, acc_busy});
    lat = 1;
    while (acc_ready !== 1'b1 && lat < 40) begin
      @(posedge clk_sys);
      #1 lat++;
    end
    if (el == 0) chk("stretch", 8'h01, {7'h0, lat > 3});
    else chk("latency", el[7:0], lat[7:0]);
    @(posedge clk_sys);
    #1 chk("release", 8'h0F, {4'h0, area_select_n});
    chk("idle", 8'h00, {7'h0, acc_busy});
  endtask : acc
  task print_verdict;
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Watchdog against a hung handshake
  initial begin
    #20000 mismatches++;
    print_verdict;
  end

  // ==================================================================
  // Main sequence
  initial begin
    rst = 1'b1; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; hold = 4'h0;
    reg_addr = 8'h00; reg_wdata = 8'h00; acc_start = 1'b0;
    acc_addr = 24'h000000;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(8'hC8 + i), 8'hFF);
    rd(8'hC0, 8'h00);
    rd(8'hC4, 8'h00);
    acc(24'h100000, 4'hF, 1'b0, 1'b0, 4);
    for (int c = 0; c < 8; c++) begin
      wr(8'hC7, 8'(c | (c << 3)));
      acc(24'h100000, 4'hF, 1'b0, c[0], 2 + w[c]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'hC0 + i), (i == 2) ? 8'hCB : 8'h8B);
      wr(8'(8'hC8 + 2 * i), 8'(16 * (i + 1)));
      wr(8'(8'hC9 + 2 * i), 8'h00);
      acc({8'(16 * (i + 1)), 16'h0}, ~(4'h1 << i), 1'b0, 1'b1, 2);
    end
    wr(8'hC3, 8'hA3);
    acc(24'h400000, 4'hF, 1'b1, 1'b0, 2);
    acc(24'h100100, 4'hF, 1'b0, 1'b1, 10);
    wr(8'hC9, 8'h01);
    acc(24'h100100, 4'hE, 1'b0, 1'b1, 2);
    rd(8'hC8, 8'h10);
    rd(8'hC9, 8'h01);
    // Clock enable low: the write must not land
    ce <= 1'b0;
    wr(8'hC8, 8'h55);
    ce <= 1'b1;
    rd(8'hC8, 8'h10);
    wr(8'hC0, 8'h82);
    acc(24'h100000, 4'hE, 1'b0, 1'b0, 3);
    hold <= 4'h6;
    acc(24'h100000, 4'hE, 1'b0, 1'b0, 0);
    hold <= 4'h0;
    wr(8'hC0, 8'h02);
    acc(24'h100000, 4'hF, 1'b0, 1'b1, 10);
    // Status: idle, last access went to the default area
    rd(8'hD0, 8'h04);
    print_verdict;
  end
endmodule : test_chip_select_wait_controller
